// ==== rtl/dirb_cfg.svh ====
// Command codes, reset values and sizes of the display id readback and unlock port
`ifndef DIRB_CFG_SVH
`define DIRB_CFG_SVH

`define DIRB_CMD_SOFT_RESET 8'h01
`define DIRB_CMD_DESC_BEGIN 8'hA1
`define DIRB_CMD_DESC_RESUME 8'hA8
`define DIRB_CMD_UNLOCK 8'hB9
`define DIRB_CMD_READ_MAKER 8'hDA
`define DIRB_CMD_READ_VERSION 8'hDB
`define DIRB_CMD_READ_DRIVER 8'hDC
`define DIRB_EXT_FIRST 8'hB0

`define DIRB_KEY_RESET 24'h00_0000
`define DIRB_KEY_ENABLE 24'hF1_1287
`define DIRB_KEY_DISABLE 24'h00_0000
`define DIRB_KEY_BYTES 2'h3

`define DIRB_DESC_EXIT 8'hFF
`define DIRB_DESC_DEPTH 4
`define DIRB_DESC_RESET 8'h00

`define DIRB_FRAME_LAST 4'h8
`define DIRB_BYTE_LAST 3'h7

`endif

// ==== rtl/dirb_pkg.sv ====
// Types shared by the display id readback and unlock port
package dirb_pkg;

    typedef struct packed {
        logic dc;
        logic [7:0] data;
    } dirb_frame_s;

    typedef struct packed {
        logic [7:0] maker;
        logic [7:0] version;
        logic [7:0] driver;
    } dirb_id_s;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_ONE = 3'b010,
        TX_DESC = 3'b100
    } dirb_tx_e;

endpackage

// ==== rtl/dirb_desc_mem.sv ====
// Small descriptor byte store with registered read data
`timescale 1ns/1ps
`include "dirb_cfg.svh"
module dirb_desc_mem #(
    parameter int DEPTH = `DIRB_DESC_DEPTH,
    parameter int AW = 2
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    // Read port
    input wire logic [AW-1:0] rd_addr_i,
    output logic [7:0] rd_data_o
);

    logic [7:0] mem [DEPTH];

    for (genvar g = 0; g < DEPTH; g++) begin : g_word
        always_ff @(posedge clk_sys_i) begin
            if (!rstn_i) begin
                mem[g] <= `DIRB_DESC_RESET;
            end else if (wr_en_i && (wr_addr_i == AW'(g))) begin
                mem[g] <= wr_data_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rd_data_o <= `DIRB_DESC_RESET;
        end else begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule

// ==== rtl/dirb_cmd_port.sv ====
// Serial command port: descriptor reads, identification reads and extended command unlock
// Operation
// - Resume command sends descriptor bytes from the first byte not yet delivered.
// - Any command may interrupt a descriptor read; read position is kept, except that A1 and soft reset 01 clear it.
// - Past the last descriptor byte the device returns FF as exit code.
// - Command DA returns one byte naming the module maker, MSB first.
// - Command DB returns one byte naming the module version.
// - Command DC returns one byte naming module and driver.
// - Identification and descriptor reads work in every power state.
// - Command B9 takes three write-only key bytes, reset zero, gating extended commands.
// - Key F1 12 87 enables extended commands only when all bytes match.
// - Key 00 00 00 disables extended commands; they are rejected until unlocked.
`timescale 1ns/1ps
`include "dirb_cfg.svh"
module dirb_cmd_port
    import dirb_pkg::*;
#(
    parameter int DESC_DEPTH = `DIRB_DESC_DEPTH,
    parameter logic [7:0] MAKER_FACTORY = 8'h5A, // Arbitrary value
    parameter logic [7:0] VERSION_FACTORY = 8'h3C, // Arbitrary value
    parameter logic [7:0] DRIVER_FACTORY = 8'hC4 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Serial command link
    input wire logic csx_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Programmed identification and descriptor contents
    input wire logic otp_done_i,
    input wire dirb_id_s otp_id_i,
    input wire logic desc_wr_en_i,
    input wire logic [$clog2(DESC_DEPTH)-1:0] desc_wr_addr_i,
    input wire logic [7:0] desc_wr_data_i,
    // Extended command set
    output logic ext_enable_o,
    output logic ext_cmd_strobe_o,
    output logic [7:0] ext_cmd_code_o,
    output logic ext_cmd_reject_o
);

    localparam int AW = $clog2(DESC_DEPTH);
    localparam int PW = $clog2(DESC_DEPTH + 1);
    localparam logic [PW-1:0] PTR_END = PW'(DESC_DEPTH);

    function automatic logic is_id_read(input logic [7:0] code);
        return (code == `DIRB_CMD_READ_MAKER) || (code == `DIRB_CMD_READ_VERSION) ||
               (code == `DIRB_CMD_READ_DRIVER);
    endfunction

    function automatic logic is_ext_code(input logic [7:0] code);
        return (code >= `DIRB_EXT_FIRST) && (code != `DIRB_CMD_UNLOCK) && !is_id_read(code);
    endfunction

    // Pin synchronisers: bit 2 chip select, bit 1 clock, bit 0 data
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic scl_prev;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pin_meta <= 3'h6;
            pin_sync <= 3'h6;
            scl_prev <= 1'b1;
        end else begin
            pin_meta <= {csx_n_i, scl_i, sda_i};
            pin_sync <= pin_meta;
            scl_prev <= pin_sync[1];
        end
    end

    wire cs_n = pin_sync[2];
    wire sda_s = pin_sync[0];
    wire scl_rise = pin_sync[1] & ~scl_prev & ~cs_n;
    wire scl_fall = ~pin_sync[1] & scl_prev & ~cs_n;

    // Receive side
    logic [3:0] rx_cnt;
    logic [7:0] rx_shift;
    dirb_tx_e tx_state;
    logic [7:0] cur_cmd;
    logic [1:0] key_idx;
    logic [23:0] key;
    logic ext_enable;

    wire tx_busy = (tx_state != TX_IDLE);
    wire rx_take = scl_rise & ~tx_busy;
    wire frame_done = rx_take & (rx_cnt == `DIRB_FRAME_LAST);
    wire dirb_frame_s frame = {rx_shift, sda_s};
    wire is_cmd = frame_done & ~frame.dc;
    wire is_par = frame_done & frame.dc;
    wire soft_reset = is_cmd & (frame.data == `DIRB_CMD_SOFT_RESET);
    wire key_par = is_par & (cur_cmd == `DIRB_CMD_UNLOCK) & (key_idx != `DIRB_KEY_BYTES);
    wire key_last = key_par & (key_idx == 2'h2);
    wire [23:0] key_full = {key[15:0], frame.data};
    wire ext_seen = is_cmd & is_ext_code(frame.data);

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || cs_n) begin
            rx_cnt <= 4'h0;
        end else if (rx_take) begin
            rx_cnt <= frame_done ? 4'h0 : rx_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rx_shift <= 8'h00;
        end else if (rx_take) begin
            rx_shift <= {rx_shift[6:0], sda_s};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            cur_cmd <= 8'h00;
            key_idx <= 2'h0;
        end else if (is_cmd) begin
            cur_cmd <= frame.data;
            key_idx <= 2'h0;
        end else if (key_par) begin
            key_idx <= key_idx + 2'h1;
        end
    end

    // Key shift and unlock decision; any key other than the enable value locks
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || soft_reset) begin
            key <= `DIRB_KEY_RESET;
            ext_enable <= 1'b0;
        end else if (key_par) begin
            key <= key_full;
            if (key_last) begin
                ext_enable <= (key_full == `DIRB_KEY_ENABLE);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ext_cmd_strobe_o <= 1'b0;
            ext_cmd_reject_o <= 1'b0;
            ext_cmd_code_o <= 8'h00;
        end else begin
            ext_cmd_strobe_o <= ext_seen & ext_enable;
            ext_cmd_reject_o <= ext_seen & ~ext_enable;
            if (ext_seen) begin
                ext_cmd_code_o <= frame.data;
            end
        end
    end

    assign ext_enable_o = ext_enable;

    // Identification bytes, reloaded by hardware and software reset
    dirb_id_s id;
    wire dirb_id_s id_factory = {MAKER_FACTORY, VERSION_FACTORY, DRIVER_FACTORY};

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || soft_reset) begin
            id <= otp_done_i ? otp_id_i : id_factory;
        end
    end

    // Transmit side; no power state input gates any read
    logic [PW-1:0] ptr;
    logic [2:0] tx_bit;
    logic tx_primed;
    logic [7:0] tx_shift;
    logic [7:0] one_byte;
    logic [7:0] mem_rdata;

    wire read_cmd = is_cmd & (is_id_read(frame.data) || (frame.data == `DIRB_CMD_DESC_BEGIN) ||
                              (frame.data == `DIRB_CMD_DESC_RESUME));
    wire byte_done = scl_rise & tx_busy & tx_primed & (tx_bit == 3'h0);
    wire [7:0] desc_byte = (ptr == PTR_END) ? `DIRB_DESC_EXIT : mem_rdata;
    wire [7:0] src_byte = (tx_state == TX_DESC) ? desc_byte : one_byte;
    wire [7:0] id_pick = (frame.data == `DIRB_CMD_READ_MAKER) ? id.maker :
                         (frame.data == `DIRB_CMD_READ_VERSION) ? id.version :
                         id.driver;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || cs_n) begin
            tx_state <= TX_IDLE;
        end else if (read_cmd) begin
            tx_state <= is_id_read(frame.data) ? TX_ONE : TX_DESC;
        end else if (byte_done && (tx_state == TX_ONE)) begin
            tx_state <= TX_IDLE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || soft_reset) begin
            ptr <= '0;
        end else if (is_cmd && (frame.data == `DIRB_CMD_DESC_BEGIN)) begin
            ptr <= '0;
        end else if (byte_done && (tx_state == TX_DESC) && (ptr != PTR_END)) begin
            ptr <= ptr + PW'(1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            one_byte <= 8'h00;
        end else if (read_cmd) begin
            one_byte <= id_pick;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || read_cmd) begin
            tx_bit <= 3'h0;
            tx_primed <= 1'b0;
            tx_shift <= 8'h00;
        end else if (scl_fall && tx_busy) begin
            tx_bit <= tx_bit + 3'h1;
            tx_primed <= 1'b1;
            tx_shift <= (tx_bit == 3'h0) ? src_byte : {tx_shift[6:0], 1'b0};
        end
    end

    assign sda_o = tx_shift[7];
    assign sda_oe_n_o = ~tx_busy | cs_n;

    dirb_desc_mem #(
        .DEPTH(DESC_DEPTH),
        .AW(AW)
    ) u_desc_mem (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .wr_en_i(desc_wr_en_i),
        .wr_addr_i(desc_wr_addr_i),
        .wr_data_i(desc_wr_data_i),
        .rd_addr_i(ptr[AW-1:0]),
        .rd_data_o(mem_rdata)
    );

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_key_match;
        key_last && (key_full == `DIRB_KEY_ENABLE);
    endsequence

    sequence s_key_zero;
        key_last && (key_full == `DIRB_KEY_DISABLE);
    endsequence

    chk_unlock_enable: assert property (s_key_match |=> ext_enable_o)
        else $error("matching key did not enable extended commands");
    chk_zero_disable: assert property (s_key_zero |=> !ext_enable_o ##1 !ext_enable_o)
        else $error("zero key did not disable extended commands");
    chk_locked_reject: assert property (ext_seen && !ext_enable |=> ext_cmd_reject_o && !ext_cmd_strobe_o)
        else $error("extended command not rejected while locked");
    chk_key_partial: assert property (key_par && !key_last |=> $stable(ext_enable_o))
        else $error("partial key changed unlock state");
    chk_exit_code: assert property (scl_fall && (tx_state == TX_DESC) && (tx_bit == 3'h0) &&
        (ptr == PTR_END) |=> (tx_shift == `DIRB_DESC_EXIT))
        else $error("exit code not sent after last descriptor byte");
    chk_maker_byte: assert property (is_cmd && (frame.data == `DIRB_CMD_READ_MAKER) |=>
        (one_byte == id.maker) && (tx_state == TX_ONE))
        else $error("maker read did not select maker byte");
    chk_version_byte: assert property (is_cmd && (frame.data == `DIRB_CMD_READ_VERSION) |=>
        (one_byte == id.version))
        else $error("version read did not select version byte");
    chk_driver_byte: assert property (is_cmd && (frame.data == `DIRB_CMD_READ_DRIVER) |=>
        (one_byte == id.driver))
        else $error("driver read did not select driver byte");
    chk_resume_keep: assert property (is_cmd && (frame.data == `DIRB_CMD_DESC_RESUME) |=>
        (ptr == $past(ptr)) && (tx_state == TX_DESC))
        else $error("resume moved the descriptor position");
    chk_cs_keep: assert property ($rose(cs_n) |=> $stable(ptr) && (tx_state == TX_IDLE))
        else $error("interrupt lost the descriptor position");
    chk_soft_reload: assert property (soft_reset |=>
        (id == ($past(otp_done_i) ? $past(otp_id_i) : id_factory)) && !ext_enable_o)
        else $error("software reset did not reload id bytes");

    sequence s_key_extra;
        is_par && (cur_cmd == `DIRB_CMD_UNLOCK) && (key_idx == `DIRB_KEY_BYTES);
    endsequence

    chk_key_extra: assert property (s_key_extra |=> $stable(key) && $stable(ext_enable_o))
        else $error("extra key byte changed unlock state");
    chk_read_any: assert property (read_cmd |=> (tx_state != TX_IDLE))
        else $error("read command not answered");
    chk_ptr_hold: assert property ((tx_state != TX_DESC) && !soft_reset &&
        !(is_cmd && (frame.data == `DIRB_CMD_DESC_BEGIN)) |=> $stable(ptr))
        else $error("descriptor position moved outside a descriptor read");
    chk_id_release: assert property (byte_done && (tx_state == TX_ONE) |=>
        sda_oe_n_o && (tx_state == TX_IDLE))
        else $error("id read did not release the data line");
    chk_strobe_code: assert property (ext_seen && ext_enable |=>
        ext_cmd_strobe_o && (ext_cmd_code_o == $past(frame.data)))
        else $error("unlocked extended command not passed on");
    chk_reject_pulse: assert property (ext_cmd_reject_o |=> !ext_cmd_reject_o)
        else $error("reject pulse longer than one cycle");

endmodule

// ==== tb/dirb_host.sv ====
// Host processor model that drives the serial command link
`timescale 1ns/1ps
module dirb_host (
    // Clock
    input wire logic clk_sys_i,
    // Serial command link
    output logic csx_n_o,
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i,
    input wire logic sda_oe_n_i
);
    initial begin
        csx_n_o = 1'b1;
        scl_o = 1'b1;
        sda_o = 1'b0;
    end

    task automatic half();
        repeat (4) @(negedge clk_sys_i);
    endtask

    // Nine-bit frame, D/C first then data MSB first; SCL rests high between frames
    task automatic send(input logic dc, input logic [7:0] b);
        logic [8:0] f;
        f = {dc, b};
        if (csx_n_o) begin
            csx_n_o = 1'b0;
            half();
        end
        for (int i = 8; i >= 0; i--) begin
            scl_o = 1'b0;
            sda_o = f[i];
            half();
            scl_o = 1'b1;
            half();
        end
    endtask

    // One byte from the device, sampled as SCL rises; oe shows it drove every bit
    task automatic recv(output logic [7:0] b, output logic oe);
        oe = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            scl_o = 1'b0;
            // Released host line keeps changing so a stale level cannot pass
            sda_o = ~sda_o;
            half();
            b[i] = sda_i;
            oe = oe & ~sda_oe_n_i;
            scl_o = 1'b1;
            half();
        end
    endtask

    task automatic stop();
        csx_n_o = 1'b1;
        half();
    endtask
endmodule

// ==== tb/tb_dirb_cmd_port.sv ====
// Self-checking bench of the serial command port
`timescale 1ns/1ps
module tb_dirb_cmd_port;
    import dirb_pkg::*;
    localparam logic [7:0] MF = 8'h6B; // Arbitrary value
    localparam logic [7:0] VF = 8'h4D; // Arbitrary value
    localparam logic [7:0] DF = 8'hB2; // Arbitrary value
    logic clk_sys_i, rstn_i, csx_n, scl, host_sda, sda_o, sda_oe_n_o, sda_line, oe;
    logic otp_done, desc_wr_en, ext_enable, ext_strobe, ext_reject;
    logic [1:0] desc_wr_addr;
    logic [7:0] desc_wr_data, ext_code, rd;
    logic [7:0] mem [4];
    logic [31:0] seed;
    dirb_id_s otp_id;
    int failures, n_checks, n_strobe, n_reject;

    assign sda_line = sda_oe_n_o ? host_sda : sda_o;

    dirb_host u_dirb_host (.clk_sys_i(clk_sys_i), .csx_n_o(csx_n), .scl_o(scl), .sda_o(host_sda),
        .sda_i(sda_line), .sda_oe_n_i(sda_oe_n_o));

    dirb_cmd_port #(.DESC_DEPTH(4), .MAKER_FACTORY(MF), .VERSION_FACTORY(VF), .DRIVER_FACTORY(DF))
    u_dirb_cmd_port (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .csx_n_i(csx_n), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .otp_done_i(otp_done),
        .otp_id_i(otp_id), .desc_wr_en_i(desc_wr_en), .desc_wr_addr_i(desc_wr_addr),
        .desc_wr_data_i(desc_wr_data), .ext_enable_o(ext_enable), .ext_cmd_strobe_o(ext_strobe),
        .ext_cmd_code_o(ext_code), .ext_cmd_reject_o(ext_reject));

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        if (ext_strobe === 1'b1) n_strobe++;
        if (ext_reject === 1'b1) n_reject++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic read_id(input logic [7:0] code, input logic [7:0] exp);
        u_dirb_host.send(1'b0, code);
        u_dirb_host.recv(rd, oe);
        check(rd, exp);
        check(oe, 1'b1);
        u_dirb_host.stop();
        check(sda_oe_n_o, 1'b1);
    endtask

    task automatic read_ids(input dirb_id_s id);
        read_id(8'hDA, id.maker);
        read_id(8'hDB, id.version);
        read_id(8'hDC, id.driver);
    endtask

    // Host side of the unlock sequence: command then three key bytes
    task automatic key(input logic [23:0] k);
        u_dirb_host.send(1'b0, 8'hB9);
        u_dirb_host.send(1'b1, k[23:16]);
        u_dirb_host.send(1'b1, k[15:8]);
        u_dirb_host.send(1'b1, k[7:0]);
        u_dirb_host.stop();
        repeat (4) @(negedge clk_sys_i);
        check(ext_enable, k === 24'hF1_1287);
    endtask

    task automatic ext(input logic [7:0] code, input logic en);
        int s;
        int r;
        s = n_strobe;
        r = n_reject;
        u_dirb_host.send(1'b0, code);
        u_dirb_host.stop();
        repeat (4) @(negedge clk_sys_i);
        check(n_strobe - s, en);
        check(n_reject - r, !en);
        check(ext_code, code);
    endtask

    task automatic hw_reset();
        rstn_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        failures++;
        test_done();
    end

    initial begin
        {otp_done, desc_wr_en, desc_wr_addr, desc_wr_data} = '0;
        otp_id = '0;
        seed = 32'hf339;
        @(negedge clk_sys_i);
        hw_reset();
        check(ext_enable, 1'b0);
        check(sda_oe_n_o, 1'b1);
        read_ids({MF, VF, DF});
        $display("Test factory ids done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            mem[i] = seed[7:0];
            desc_wr_en = 1'b1;
            desc_wr_addr = i[1:0];
            desc_wr_data = mem[i];
            @(negedge clk_sys_i);
        end
        desc_wr_en = 1'b0;
        u_dirb_host.send(1'b0, 8'hA1);
        for (int i = 0; i < 2; i++) begin
            u_dirb_host.recv(rd, oe);
            check(rd, mem[i]);
        end
        u_dirb_host.stop();
        read_id(8'hDB, VF);
        u_dirb_host.send(1'b0, 8'hA8);
        for (int i = 2; i < 6; i++) begin
            u_dirb_host.recv(rd, oe);
            check(rd, (i < 4) ? mem[i] : 8'hFF);
        end
        u_dirb_host.stop();
        $display("Test descriptor resume done");
        seed = lfsr(seed);
        ext({4'hC, seed[3:0]}, 1'b0);
        u_dirb_host.send(1'b0, 8'hB9);
        u_dirb_host.send(1'b1, 8'hF1);
        u_dirb_host.send(1'b1, 8'h12);
        u_dirb_host.stop();
        key(24'hF1_1286);
        key(24'hF1_1287);
        seed = lfsr(seed);
        ext({4'hE, seed[3:0]}, 1'b1);
        key(24'h00_0000);
        ext(8'hC5, 1'b0);
        key(24'hF1_1287);
        key(seed[23:0]);
        $display("Test unlock done");
        key(24'hF1_1287);
        u_dirb_host.send(1'b1, 8'h00);
        u_dirb_host.stop();
        repeat (4) @(negedge clk_sys_i);
        check(ext_enable, 1'b1);
        otp_done = 1'b1;
        seed = lfsr(seed);
        otp_id = seed[23:0];
        u_dirb_host.send(1'b0, 8'h01);
        u_dirb_host.stop();
        repeat (4) @(negedge clk_sys_i);
        check(ext_enable, 1'b0);
        read_ids(otp_id);
        seed = lfsr(seed);
        otp_id = seed[23:0];
        hw_reset();
        read_ids(otp_id);
        $display("Test id reload done");
        test_done();
    end
endmodule
